// ---- verilog/scan_master_processor_port.sv ----
// Purpose: Processor port of the scan test master: handshake, registers, status
// Assumes: Synchronous external buffer memory with read data valid within 3 clocks
// Notes: Serial scan logic sits outside and talks through strobes and flags
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "scan_port_consts.svh"
module scan_master_processor_port
#(
	parameter int ADDR_W = 5,
	parameter int MEM_AW = 11,
	parameter int FILL_W = 10,
	parameter int BUF_DEPTH = 512,
	parameter logic [10:0] OUT_BASE = 11'h000,
	parameter logic [10:0] IN_BASE = 11'h200
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic async_mode,
	input wire logic ce_n,
	input wire logic access_strobe_n,
	input wire logic rw,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata,
	output logic transfer_ack_n,
	output logic irq,
	output logic [MEM_AW-1:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	input wire logic [31:0] mem_rdata,
	output logic ctrl_strobe,
	output logic use_seq,
	output logic [2:0] use_vec,
	output logic tdo_default,
	output logic trst,
	output logic bridge_en,
	output logic [2:0] sync_len,
	output logic [1:0] loopback,
	output logic [15:0] clk_div,
	output logic [2:0] signature_compressor_exp,
	output logic [31:0] signature_compressor_seed,
	output logic out_empty,
	output logic in_full,
	input wire logic signature_result_strobe,
	input wire logic [31:0] signature_result,
	input wire logic cmp_value,
	input wire logic cmp_load,
	input wire logic cmp_clear,
	input wire logic seq_active,
	input wire logic [2:0] vec_active,
	input wire logic out_cnt_en,
	input wire logic in_cnt_en
);

	// Whole module state
	typedef struct packed {
		scan_port_pkg::pic_state_e pic;
		logic ack_n;
		logic [2:0] cnt;
		logic [ADDR_W-1:0] a;
		logic [31:0] rdata;
		logic [31:0] cap;
		logic [15:0] wlo;
		logic half;
		logic [3:0] start;
		logic [3:0] int_en;
		logic [15:0] setup;
		logic [15:0] clk_div;
		logic [2:0] signature_compressor_exp;
		logic [15:0] seed_lo;
		logic [15:0] seed_hi;
		logic cfg_we;
		logic cfg_we_d;
		logic [15:0] res_lo;
		logic [15:0] res_hi;
		logic cmp;
		logic [3:0] cond;
		logic [3:0] flags;
		logic [3:0] int_st;
		logic [MEM_AW-1:0] out_ptr;
		logic [MEM_AW-1:0] in_ptr;
		logic [FILL_W-1:0] out_fill;
		logic [FILL_W-1:0] in_fill;
		logic mem_we;
		logic mem_re;
		logic [MEM_AW-1:0] mem_addr;
		logic [31:0] mem_wdata;
	} port_s;

	localparam logic [FILL_W-1:0] HALF_LVL = FILL_W'(BUF_DEPTH / 2);
	localparam logic [FILL_W-1:0] FULL_LVL = FILL_W'(BUF_DEPTH);

	port_s st_ff;
	port_s nxt_st;
	logic [1:0] lvl_n;
	logic stb_fall;
	logic stb_rise;
	logic bus32;
	logic [3:0] cond_now;
	logic [3:0] flag_set;
	logic [3:0] flag_clr;

	// Strobe and chip enable synchroniser and edge detector
	strobe_edge_detect u_edge
	(
		.clk(clk),
		.rst(rst),
		.async_mode(async_mode),
		.pin_n({ce_n, access_strobe_n}),
		.lvl_n(lvl_n),
		.fall(stb_fall),
		.rise(stb_rise)
	);

	assign bus32 = st_ff.setup[`SETUP_BUS32];

	// Flag conditions: out empty, out half empty, in half full, in full
	assign cond_now[0] = (st_ff.out_fill == '0);
	assign cond_now[1] = (st_ff.out_fill <= HALF_LVL);
	assign cond_now[2] = (st_ff.in_fill >= HALF_LVL);
	assign cond_now[3] = (st_ff.in_fill >= FULL_LVL);
	// Load on a new condition, clear once it no longer holds
	assign flag_set = cond_now & ~st_ff.cond;
	assign flag_clr = ~cond_now & st_ff.cond;

	// Register read mux; narrow fields sit in the low bits
	function automatic logic [15:0] reg_read(input logic [ADDR_W-1:0] a, input port_s s);
		logic [15:0] v;
		v = 16'h0000;
		case (a)
			`OFS_START: v[3:0] = s.start;
			`OFS_INT_CTRL: v[3:0] = s.int_en;
			`OFS_SETUP: v = s.setup;
			`OFS_CLK_DIV: v = s.clk_div;
			`OFS_SIGNATURE_COMPRESSOR_EXP: v[2:0] = s.signature_compressor_exp;
			`OFS_SEED_LO: v = s.seed_lo;
			`OFS_SEED_HI: v = s.seed_hi;
			`OFS_STATUS:
			begin
				v[3:0] = s.flags;
				v[`ST_SEQ] = seq_active;
				v[`ST_VEC_LO+2:`ST_VEC_LO] = vec_active;
				v[`ST_CMP] = s.cmp;
			end
			`OFS_INT_STAT: v[3:0] = s.int_st;
			`OFS_RES_LO: v = s.res_lo;
			`OFS_RES_HI: v = s.res_hi;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction : reg_read

	// All next-state logic
	always_comb
	begin
		logic is_mem;
		logic out_inc;
		logic in_dec;
		logic rd_clr;
		is_mem = 1'b0;
		out_inc = 1'b0;
		in_dec = 1'b0;
		rd_clr = 1'b0;
		nxt_st = st_ff;
		nxt_st.cfg_we = 1'b0;
		nxt_st.mem_we = 1'b0;
		nxt_st.mem_re = 1'b0;
		nxt_st.cfg_we_d = st_ff.cfg_we;

		// Access controller
		case (st_ff.pic)
			scan_port_pkg::PIC_IDLE:
			begin
				// Strobe fall with chip enable low starts an access
				if (stb_fall && !lvl_n[1])
				begin
					nxt_st.a = addr;
					is_mem = (addr == `OFS_OUT_BUF) || (addr == `OFS_IN_BUF);
					if (!rw)
					begin
						// Write takes effect and acknowledges on this edge
						nxt_st.ack_n = 1'b0;
						nxt_st.pic = scan_port_pkg::PIC_ACK;
						case (addr)
							`OFS_START:
							begin
								nxt_st.start = wdata[3:0];
								nxt_st.cfg_we = 1'b1;
							end
							`OFS_INT_CTRL: nxt_st.int_en = wdata[3:0];
							`OFS_SETUP:
							begin
								nxt_st.setup = wdata[15:0];
								nxt_st.cfg_we = 1'b1;
							end
							`OFS_CLK_DIV: nxt_st.clk_div = wdata[15:0];
							`OFS_SIGNATURE_COMPRESSOR_EXP: nxt_st.signature_compressor_exp = wdata[2:0];
							`OFS_SEED_LO: nxt_st.seed_lo = wdata[15:0];
							`OFS_SEED_HI: nxt_st.seed_hi = wdata[15:0];
							`OFS_INDEX:
							begin
								nxt_st.out_ptr = wdata[MEM_AW-1:0];
								nxt_st.in_ptr = wdata[MEM_AW-1:0];
							end
							`OFS_OUT_BUF:
							begin
								// 16-bit mode: low word first, write on second
								if (!bus32 && !st_ff.half)
								begin
									nxt_st.wlo = wdata[15:0];
									nxt_st.half = 1'b1;
								end
								else
								begin
									nxt_st.mem_we = 1'b1;
									nxt_st.mem_addr = MEM_AW'(OUT_BASE + st_ff.out_ptr);
									nxt_st.mem_wdata = bus32 ? wdata : {wdata[15:0], st_ff.wlo};
									nxt_st.out_ptr = st_ff.out_ptr + 1'b1;
									nxt_st.half = 1'b0;
									out_inc = 1'b1;
								end
							end
							default: nxt_st.ack_n = 1'b0;
						endcase
					end
					else
					begin
						// Reads wait for data before acknowledging
						nxt_st.pic = scan_port_pkg::PIC_WAIT;
						nxt_st.cnt = `WAIT_REG_RD;
						if (addr == `OFS_IN_BUF)
						begin
							if (bus32 || !st_ff.half)
							begin
								nxt_st.mem_re = 1'b1;
								nxt_st.mem_addr = MEM_AW'(IN_BASE + st_ff.in_ptr);
								nxt_st.cnt = `WAIT_MEM_RD1;
							end
							else
							begin
								nxt_st.cnt = `WAIT_MEM_RD2;
							end
						end
					end
					// A register access restarts the word pairing
					if (!is_mem)
						nxt_st.half = 1'b0;
				end
			end
			scan_port_pkg::PIC_WAIT:
			begin
				nxt_st.cnt = st_ff.cnt - 1'b1;
				if (st_ff.cnt == 3'h1)
				begin
					nxt_st.ack_n = 1'b0;
					nxt_st.pic = scan_port_pkg::PIC_ACK;
					if (st_ff.a == `OFS_IN_BUF)
					begin
						if (bus32)
						begin
							nxt_st.rdata = mem_rdata;
							nxt_st.in_ptr = st_ff.in_ptr + 1'b1;
							in_dec = 1'b1;
						end
						else if (!st_ff.half)
						begin
							// First access captures the whole word
							nxt_st.cap = mem_rdata;
							nxt_st.rdata = {16'h0000, mem_rdata[15:0]};
							nxt_st.half = 1'b1;
						end
						else
						begin
							nxt_st.rdata = {16'h0000, st_ff.cap[31:16]};
							nxt_st.half = 1'b0;
							nxt_st.in_ptr = st_ff.in_ptr + 1'b1;
							in_dec = 1'b1;
						end
					end
					else
					begin
						nxt_st.rdata = {16'h0000, reg_read(st_ff.a, st_ff)};
						rd_clr = (st_ff.a == `OFS_INT_STAT);
					end
				end
			end
			scan_port_pkg::PIC_ACK:
			begin
				// Strobe release ends the cycle
				if (stb_rise)
				begin
					nxt_st.ack_n = `ACK_OFF;
					nxt_st.pic = scan_port_pkg::PIC_IDLE;
				end
			end
			default:
			begin
				nxt_st.pic = scan_port_pkg::PIC_IDLE;
				nxt_st.ack_n = `ACK_OFF;
			end
		endcase

		// Result capture from the serial side
		if (signature_result_strobe)
		begin
			nxt_st.res_lo = signature_result[15:0];
			nxt_st.res_hi = signature_result[31:16];
		end

		// Compare bit; clear taken before load so a load wins
		if (cmp_clear)
			nxt_st.cmp = `CMP_FAIL;
		if (cmp_load)
			nxt_st.cmp = cmp_value;

		// Status flags follow the set and clear pulses always
		nxt_st.cond = cond_now;
		nxt_st.flags = (st_ff.flags & ~flag_clr) | flag_set;

		// Read clears, a coinciding event still lands afterwards
		nxt_st.int_st = (rd_clr ? 4'h0 : st_ff.int_st) | (flag_set & st_ff.int_en);

		// Simultaneous up and down cancel out
		nxt_st.out_fill = st_ff.out_fill + FILL_W'(out_inc) - FILL_W'(out_cnt_en);
		nxt_st.in_fill = st_ff.in_fill + FILL_W'(in_cnt_en) - FILL_W'(in_dec);
	end

	// State register; reset leaves acknowledge off and compare at fail
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_ff <= '0;
			st_ff.pic <= scan_port_pkg::PIC_IDLE;
			st_ff.ack_n <= `ACK_OFF;
			st_ff.cmp <= `CMP_FAIL;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign rdata = st_ff.rdata;
	assign transfer_ack_n = st_ff.ack_n;
	assign irq = |(st_ff.int_st & st_ff.int_en);
	assign mem_addr = st_ff.mem_addr;
	assign mem_wdata = st_ff.mem_wdata;
	assign mem_we = st_ff.mem_we;
	assign mem_re = st_ff.mem_re;
	// Rising edge of the config write enable makes the strobe
	assign ctrl_strobe = st_ff.cfg_we & ~st_ff.cfg_we_d;
	assign use_seq = st_ff.start[0];
	assign use_vec = st_ff.start[3:1];
	assign tdo_default = st_ff.setup[`SETUP_TDO_DEF];
	assign trst = st_ff.setup[`SETUP_TRST];
	assign bridge_en = st_ff.setup[`SETUP_BRIDGE];
	assign sync_len = st_ff.setup[`SETUP_SYNC_LO+2:`SETUP_SYNC_LO];
	assign loopback = st_ff.setup[`SETUP_LOOP_LO+1:`SETUP_LOOP_LO];
	assign clk_div = st_ff.clk_div;
	assign signature_compressor_exp = st_ff.signature_compressor_exp;
	assign signature_compressor_seed = {st_ff.seed_hi, st_ff.seed_lo};
	assign out_empty = st_ff.flags[0];
	assign in_full = st_ff.flags[3];

endmodule : scan_master_processor_port

// ---- verilog/scan_port_consts.svh ----
// Purpose: Offsets, field positions and timing counts of the processor port
// Assumes: Included by bare name wherever a constant is needed
// Notes: Operation list of the port follows
// Operation
// - Start or setup write strobes serial side
// - Forward start and setup control fields
// - Result strobe captures low and high halves
// - Compare bit loads and clears from serial
// - Buffer flags update regardless of enables
// - Sequencer and vector activity always in status
// - Four enables gate flag interrupts
// - Interrupt status clears on read, keeps events
// - Flag logic issues set and clear pulses
// - Out-empty and in-full go to serial side
// - Fill counters; inc plus dec holds
// - Register access same in both modes
// - 16-bit memory write on second access
// - Write acknowledged at strobe fall edge
// - Strobe rise withdraws acknowledge
// - Read acknowledge one clock later
// - Memory read five clocks, then three
// - Async mode syncs strobe and enable
// - Setup bit picks 16 or 32 bit bus
`ifndef SCAN_PORT_CONSTS_SVH
`define SCAN_PORT_CONSTS_SVH

// Register offsets on the port address
`define OFS_START 5'h00
`define OFS_INT_CTRL 5'h01
`define OFS_SETUP 5'h02
`define OFS_CLK_DIV 5'h03
`define OFS_SIGNATURE_COMPRESSOR_EXP 5'h04
`define OFS_SEED_LO 5'h05
`define OFS_SEED_HI 5'h06
`define OFS_STATUS 5'h07
`define OFS_INT_STAT 5'h08
`define OFS_RES_LO 5'h09
`define OFS_RES_HI 5'h0a
`define OFS_INDEX 5'h0b
`define OFS_OUT_BUF 5'h0c
`define OFS_IN_BUF 5'h0d

// Setup register fields
`define SETUP_TDO_DEF 0
`define SETUP_BUS32 1
`define SETUP_BRIDGE 2
`define SETUP_TRST 5
`define SETUP_SYNC_LO 6
`define SETUP_LOOP_LO 9

// Status register fields
`define ST_SEQ 4
`define ST_VEC_LO 5
`define ST_CMP 15

// Wait clocks after the strobe fall edge before acknowledge
`define WAIT_REG_RD 3'h1
`define WAIT_MEM_RD1 3'h4
`define WAIT_MEM_RD2 3'h2

// Reset values
`define CMP_FAIL 1'b0
`define ACK_OFF 1'b1

`endif

// ---- verilog/scan_port_pkg.sv ----
// Purpose: Shared types of the processor port
// Assumes: Used as scan_port_pkg::name, never imported
// Notes: Constants live in the consts header
package scan_port_pkg;

	// Access controller states
	typedef enum logic [1:0] {
		PIC_IDLE = 2'b00,
		PIC_WAIT = 2'b01,
		PIC_ACK = 2'b10
	} pic_state_e;

	// Edge detector state: two sync stages and previous strobe level
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic prev;
	} edge_s;

endpackage : scan_port_pkg

// ---- verilog/strobe_edge_detect.sv ----
// Purpose: Synchronise chip enable and strobe, detect strobe edges
// Assumes: Bit 0 is the strobe, bit 1 the chip enable, both active low
// Notes: In sync mode the raw pins feed the edge logic directly
`timescale 1ns/1ps
module strobe_edge_detect
(
	input wire logic clk,
	input wire logic rst,
	input wire logic async_mode,
	input wire logic [1:0] pin_n,
	output logic [1:0] lvl_n,
	output logic fall,
	output logic rise
);

	scan_port_pkg::edge_s st_ff;
	scan_port_pkg::edge_s nxt_st;

	// Per-bit two-stage pipe; stage one feeds only stage two
	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_sync
			assign lvl_n[i] = async_mode ? st_ff.s2[i] : pin_n[i];
		end
	endgenerate

	// Edge pulses are one clock wide
	assign fall = st_ff.prev & ~lvl_n[0];
	assign rise = ~st_ff.prev & lvl_n[0];

	// Next state
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = pin_n;
		nxt_st.s2 = st_ff.s1;
		nxt_st.prev = lvl_n[0];
	end

	// Idle strobe level is high after reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_ff <= '{s1: 2'h3, s2: 2'h3, prev: 1'b1};
		else
			st_ff <= nxt_st;
	end

endmodule : strobe_edge_detect

// ---- verif/buffer_mem_model.sv ----
// Purpose: Behavioural buffer memory on the far side of the processor port
// Assumes: Read data wanted three clocks after the read pulse
// Notes: Data stands one cycle only, then turns over each clock
`timescale 1ns/1ps
module buffer_mem_model
(
	input wire logic clk,
	input wire logic [10:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_we,
	input wire logic mem_re,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [0:2047]; // Word store
	logic [10:0] rd_addr = 11'h000; // Latched read address
	logic [1:0] rd_pipe = 2'h0; // Read latency stages
	initial mem_rdata = 32'h0;
	// Late, single-cycle data so a lazy sampler is caught
	always @(posedge clk)
	begin
		rd_pipe <= {rd_pipe[0], mem_re};
		if (mem_re)
			rd_addr <= mem_addr;
		if (rd_pipe[1])
			mem_rdata <= mem[rd_addr];
		else
			mem_rdata <= ~mem_rdata;
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
	end
endmodule : buffer_mem_model

// ---- verif/scan_master_processor_port_chk.sv ----
// Purpose: Handshake and strobe checks on the processor port
// Assumes: Edge checks on the strobe apply in sync host mode
// Notes: Bound to every instance of the port
`timescale 1ns/1ps
`include "scan_port_consts.svh"
module scan_master_processor_port_chk
#(
	parameter int ADDR_W = 5
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic async_mode,
	input wire logic ce_n,
	input wire logic access_strobe_n,
	input wire logic rw,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic transfer_ack_n,
	input wire logic mem_re,
	input wire logic mem_we,
	input wire logic ctrl_strobe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Strobe fall taken by an idle port
	sequence taken_s;
		!async_mode && $fell(access_strobe_n) && !ce_n && transfer_ack_n;
	endsequence
	// Write to start or setup
	sequence ctrl_wr_s;
		taken_s ##0 (!rw && (addr == `OFS_START || addr == `OFS_SETUP));
	endsequence
	a_write_ack_now: assert property (taken_s ##0 !rw |=> !transfer_ack_n)
		else $error("write not acknowledged at strobe fall");
	a_reg_read_late: assert property (taken_s ##0 (rw && addr < `OFS_OUT_BUF)
		|=> transfer_ack_n ##1 !transfer_ack_n)
		else $error("register read ack not one clock late");
	a_ack_stands: assert property (!transfer_ack_n && !access_strobe_n |=> !transfer_ack_n)
		else $error("ack dropped while strobe low");
	a_ack_release: assert property (!async_mode && !transfer_ack_n && $rose(access_strobe_n)
		|=> transfer_ack_n)
		else $error("ack not withdrawn at strobe rise");
	a_unselected_ignored: assert property (!async_mode && $fell(access_strobe_n) && ce_n
		&& transfer_ack_n |=> transfer_ack_n [*2])
		else $error("strobe without chip enable answered");
	a_ctrl_after_write: assert property (ctrl_wr_s |-> ##[1:2] ctrl_strobe)
		else $error("no control strobe after start or setup write");
	a_ctrl_one_pulse: assert property (ctrl_strobe |=> !ctrl_strobe)
		else $error("control strobe longer than one clock");
	a_mem_read_wait: assert property (mem_re |-> transfer_ack_n [*4] ##1 !transfer_ack_n)
		else $error("first memory read ack not at five clocks");
	a_mem_re_cause: assert property (mem_re |-> $past(access_strobe_n) == 1'b0 && $past(rw))
		else $error("memory read without a read access");
	a_mem_we_pulse: assert property (mem_we |=> !mem_we)
		else $error("memory write longer than one clock");
endmodule : scan_master_processor_port_chk

bind scan_master_processor_port scan_master_processor_port_chk #(.ADDR_W(ADDR_W)) chk_i (
	.clk(clk), .rst(rst), .async_mode(async_mode), .ce_n(ce_n),
	.access_strobe_n(access_strobe_n), .rw(rw), .addr(addr),
	.transfer_ack_n(transfer_ack_n), .mem_re(mem_re), .mem_we(mem_we),
	.ctrl_strobe(ctrl_strobe));

// ---- verif/scan_master_processor_port_tb.sv ----
// Purpose: Self-checking bench for the processor port, mostly in sync host mode
// Assumes: Default parameters, buffer memory model on the far side
// Notes: A short async host phase covers the two sync stages
`timescale 1ns/1ps
`include "scan_port_consts.svh"
module scan_master_processor_port_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce_n = 1'b1;
	logic access_strobe_n = 1'b1;
	logic rw = 1'b1;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, mem_wdata, mem_rdata;
	logic transfer_ack_n, irq, mem_we, mem_re, ctrl_strobe, use_seq;
	logic tdo_default, trst, bridge_en, out_empty, in_full;
	logic [10:0] mem_addr;
	logic [2:0] use_vec, sync_len;
	logic [1:0] loopback;
	logic async_mode = 1'b0; // Host mode select
	logic [15:0] clk_div; // Divider register level
	logic [2:0] signature_compressor_exp; // Exponent register level
	logic [31:0] signature_compressor_seed; // Seed halves joined
	int last_wait = 0; // Clocks from first strobe edge to ack seen
	logic [4:0] pls = 5'h00; // Serial pulses: result, load, clear, out, in
	logic [31:0] sig_res = 32'h0;
	logic cmp_value = 1'b0;
	logic seq_active = 1'b0;
	logic [2:0] vec_active = 3'h0;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int we_count = 0; // Memory writes seen
	logic [31:0] we_data = 32'h0; // Last word written
	always #50 clk = ~clk;
	scan_master_processor_port scan_master_processor_port_i (.clk(clk), .rst(rst),
		.async_mode(async_mode), .ce_n(ce_n), .access_strobe_n(access_strobe_n), .rw(rw),
		.addr(addr), .wdata(wdata), .rdata(rdata), .transfer_ack_n(transfer_ack_n),
		.irq(irq), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.mem_re(mem_re), .mem_rdata(mem_rdata), .ctrl_strobe(ctrl_strobe),
		.use_seq(use_seq), .use_vec(use_vec), .tdo_default(tdo_default), .trst(trst),
		.bridge_en(bridge_en), .sync_len(sync_len), .loopback(loopback),
		.clk_div(clk_div), .signature_compressor_exp(signature_compressor_exp), .signature_compressor_seed(signature_compressor_seed),
		.out_empty(out_empty), .in_full(in_full),
		.signature_result_strobe(pls[0]), .signature_result(sig_res),
		.cmp_value(cmp_value), .cmp_load(pls[1]), .cmp_clear(pls[2]),
		.seq_active(seq_active), .vec_active(vec_active), .out_cnt_en(pls[3]),
		.in_cnt_en(pls[4]));
	buffer_mem_model buffer_mem_model_i (.clk(clk), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
	// Record memory writes for the pairing checks
	always @(posedge clk)
	begin
		cycles++;
		if (mem_we === 1'b1)
		begin
			we_count <= we_count + 1;
			we_data <= mem_wdata;
		end
		if (cycles == 20000)
		begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One bus access; strobe held until ack, ce held until ack drops
	task automatic access(input logic is_rd, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		logic got;
		n = 0;
		@(posedge clk);
		ce_n <= 1'b0;
		rw <= is_rd;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		access_strobe_n <= 1'b0;
		@(posedge clk);
		while (transfer_ack_n !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		// A missing ack must fail even though the release loop then ends at once
		got = (transfer_ack_n === 1'b0);
		last_wait = n;
		q = rdata;
		access_strobe_n <= 1'b1;
		while (transfer_ack_n !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		ce_n <= 1'b1;
		check({30'h0, got, n < 40}, 32'h3, "handshake");
	endtask : access
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		access(1'b0, a, d, q);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		access(1'b1, a, 32'h0, q);
		check(q, exp, what);
	endtask : rd
	// Serial side pulses, one clock each, k times
	task automatic pulse(input logic [4:0] m, input int k);
		repeat (k)
		begin
			@(posedge clk);
			pls <= m;
			@(posedge clk);
			pls <= 5'h00;
		end
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check({rdata[29:0], transfer_ack_n, irq}, 32'h2, "reset outputs");
		rd(`OFS_STATUS, 32'h3, "status after reset");
		rd(`OFS_INT_STAT, 32'h0, "int status after reset");
		rd(5'h1e, 32'h0, "unmapped read");
		$display("reset test done");
		wr(`OFS_START, 32'habcd000f);
		check(last_wait, 32'h1, "write ack clocks");
		check({27'h0, use_seq, use_vec}, 32'hf, "start fields");
		rd(`OFS_START, 32'hf, "start low word only");
		check(last_wait, 32'h2, "read ack clocks");
		wr(`OFS_SETUP, 32'h00000765);
		check({24'h0, tdo_default, bridge_en, trst, sync_len, loopback}, 32'hf7, "setup");
		$display("control test done");
		seq_active <= 1'b1;
		vec_active <= 3'h5;
		rd(`OFS_STATUS, 32'hb3, "live activity");
		cmp_value <= 1'b1;
		pulse(5'h02, 1);
		rd(`OFS_STATUS, 32'h80b3, "compare loaded");
		pulse(5'h04, 1);
		rd(`OFS_STATUS, 32'hb3, "compare cleared");
		sig_res <= 32'h12345678;
		pulse(5'h01, 1);
		rd(`OFS_RES_LO, 32'h5678, "result low");
		rd(`OFS_RES_HI, 32'h1234, "result high");
		$display("status test done");
		wr(`OFS_INDEX, 32'h0);
		for (int e = 0; e < 2; e++)
		begin
			wr(`OFS_INT_CTRL, e);
			wr(`OFS_OUT_BUF, 32'h1111);
			check(we_count, e, "no write on first half");
			wr(`OFS_OUT_BUF, 32'h2222);
			check(we_data, 32'h22221111, "word from halves");
			check({31'h0, out_empty}, 32'h0, "out buffer filled");
			pulse(5'h08, 1);
			check({30'h0, out_empty, irq}, {31'h1, e[0]}, "empty flag and irq");
			rd(`OFS_INT_STAT, e, "int status");
			check({31'h0, irq}, 32'h0, "irq after read");
			rd(`OFS_INT_STAT, 32'h0, "int status cleared");
		end
		$display("interrupt test done");
		buffer_mem_model_i.mem[11'h200] = 32'hcafe1234;
		buffer_mem_model_i.mem[11'h201] = 32'h5555aaaa;
		wr(`OFS_INDEX, 32'h0);
		pulse(5'h10, 3);
		rd(`OFS_IN_BUF, 32'h1234, "first half read");
		check(last_wait, 32'h5, "first memory read clocks");
		rd(`OFS_IN_BUF, 32'hcafe, "second half read");
		check(last_wait, 32'h3, "second memory read clocks");
		wr(`OFS_SETUP, 32'h2);
		rd(`OFS_IN_BUF, 32'h5555aaaa, "full word read");
		wr(`OFS_OUT_BUF, 32'h89abcdef);
		check(we_data, 32'h89abcdef, "full word write");
		check({31'h0, in_full}, 32'h0, "in buffer not full");
		// Async host mode: two sync stages delay the take by two clocks
		async_mode <= 1'b1;
		wr(`OFS_CLK_DIV, 32'hffff0004);
		check(last_wait, 32'h3, "async write ack clocks");
		wr(`OFS_SIGNATURE_COMPRESSOR_EXP, 32'h5);
		wr(`OFS_SEED_LO, 32'h9abc);
		wr(`OFS_SEED_HI, 32'h1357);
		rd(`OFS_CLK_DIV, 32'h4, "async divider read");
		check({clk_div, 13'h0, signature_compressor_exp}, 32'h00040005, "divider and exponent");
		check(signature_compressor_seed, 32'h13579abc, "seed halves");
		async_mode <= 1'b0;
		@(posedge clk);
		access_strobe_n <= 1'b0;
		repeat (3) @(posedge clk);
		check({31'h0, transfer_ack_n}, 32'h1, "unselected strobe");
		access_strobe_n <= 1'b1;
		$display("memory test done");
		report_and_stop();
	end
endmodule : scan_master_processor_port_tb
